// ---- hw/tsm_ana_decode.sv ----
// Purpose: Turns the analog selection into one switch enable per node
// Assumes: One analog switch per observable node drives the auxiliary pin
// Notes:   Reserved selections open every switch

`default_nettype none

module tsm_ana_decode #(
  parameter int COUNT = tsm_pkg::ANA_COUNT
) (
  input  wire logic [4:0]       sel,
  output logic [COUNT-1:0]      sw_en,
  output logic                  rsv
);

  // ==========================================================================
  // One-hot switch decode
  for (genvar i = 0; i < COUNT; i++) begin : g_sw
    assign sw_en[i] = (sel == 5'(i));  // [RQ18]
  end

  assign rsv = (sel >= 5'(COUNT));  // [RQ22]

endmodule // tsm_ana_decode

`default_nettype wire

// ---- hw/tsm_dig_mux.sv ----
// Purpose: Picks one digital test source from the seven-bit code
// Assumes: Sources are synchronous to pclk
// Notes:   Combinational; the caller registers the result

`default_nettype none

module tsm_dig_mux (
  input  wire logic [6:0]       code,
  input  wire tsm_pkg::tsm_src_s src,
  output logic                  dig_bit,
  output logic                  dig_none,
  output logic                  dig_rsv
);

  // ==========================================================================
  // Code decode
  always_comb begin
    dig_bit  = 1'b0;
    dig_none = 1'b0;
    dig_rsv  = 1'b0;
    unique case (code)
      tsm_pkg::DIG_RX_DATA[6:0]:  dig_bit = src.rx_data;     // [RQ8]
      tsm_pkg::DIG_RX_VALID[6:0]: dig_bit = src.rx_valid;    // [RQ9]
      tsm_pkg::DIG_RX_COLL[6:0]:  dig_bit = src.rx_coll;     // [RQ10]
      tsm_pkg::DIG_SER_CLK[6:0]:  dig_bit = src.serial_clk;  // [RQ11]
      tsm_pkg::DIG_RD_SYNC[6:0]:  dig_bit = src.rd_sync;     // [RQ12]
      tsm_pkg::DIG_WR_SYNC[6:0]:  dig_bit = src.wr_sync;     // [RQ13]
      tsm_pkg::DIG_INT_CLK[6:0]:  dig_bit = src.int_clk;     // [RQ14]
      tsm_pkg::DIG_NONE[6:0]:     dig_none = 1'b1;           // [RQ15]
      default:                    dig_rsv = 1'b1;            // [RQ23]
    endcase
  end

endmodule // tsm_dig_mux

`default_nettype wire

// ---- hw/tsm_observe_top.sv ----
// Purpose: Observation multiplexers for the serial and auxiliary pins
// Assumes: APB slave, single 200 MHz clock, sources synchronous to pclk
// Notes:   Pin and switch outputs lag the selecting register by one cycle
//
// Behaviour
// RQ1 - Routing off: select 0 drives low, select 1 drives high, 6 and 7 reserved
// RQ2 - Select 3 with routing off shows transmit data in NRZ form
// RQ3 - Select 2 shows the Miller-coded transmit envelope
// RQ4 - Select 4 shows Manchester-decoded receive signal with subcarrier
// RQ5 - Select 5 shows Manchester-decoded receive signal without subcarrier
// RQ6 - Routing bit set puts the chosen digital test signal on the pin
// RQ7 - Digital test source is chosen by a seven-bit field
// RQ8 - Code F4h routes received serial data
// RQ9 - Code E4h routes the receive valid qualifier
// RQ10 - Code D4h routes the collision-in-current-bit flag
// RQ11 - Code C4h routes the internal serial clock
// RQ12 - Code B5h routes the synchronized host read strobe
// RQ13 - Code A5h routes the synchronized host write strobe
// RQ14 - Code 96h routes the internal system clock
// RQ15 - Code 00h selects nothing; the serial selection governs the pin
// RQ16 - Software keeps the digital select at 00h when unused
// RQ17 - Software programs only the listed digital codes
// RQ18 - Auxiliary pin node is chosen by a five-bit analog field
// RQ19 - Analog 0 is mid-supply node, 1 is bandgap reference
// RQ20 - Analog 2, 3 demodulator outputs; 4, 5 amplified subcarriers
// RQ21 - Analog 6 to 9 are N and D correlator outputs, I then Q
// RQ22 - Analog 10 to 12 half-bit evaluations and temperature; 13 up reserved
// RQ23 - Reserved serial or digital selections drive the pin low

`default_nettype none

module tsm_observe_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [tsm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire tsm_pkg::tsm_src_s         src,
  output logic                           serial_observe_pin,
  output logic [tsm_pkg::ANA_COUNT-1:0]  analog_switch_en,
  output logic                           analog_park
);

  // ==========================================================================
  // Declarations
  tsm_pkg::tsm_sersel_e               serial_observe_select;
  logic                               digital_test_route_bit;
  logic [tsm_pkg::DIG_SEL_W-1:0]      digital_test_select_reg;
  logic [tsm_pkg::ANA_SEL_W-1:0]      analog_test_select_reg;
  logic                               pin_reg;
  logic                               pin_next;
  logic                               rsv_reg;
  logic                               rsv_next;
  logic [tsm_pkg::ANA_COUNT-1:0]      ana_sw_reg;
  logic [tsm_pkg::ANA_COUNT-1:0]      ana_sw_next;
  logic                               ana_rsv_reg;
  logic                               ana_rsv_next;
  logic [31:0]                        prdata_reg;
  logic [31:0]                        rd_next;
  logic                               pready_reg;
  logic                               pslverr_reg;
  logic                               ser_bit;
  logic                               ser_rsv;
  logic                               dig_bit;
  logic                               dig_none;
  logic                               dig_rsv;
  logic [tsm_pkg::DIG_FIELD_W-1:0]    digital_test_source_field;
  logic                               apb_setup;
  logic                               apb_access;
  logic                               addr_hit;
  logic                               wr_en;

  // ==========================================================================
  // APB decode
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable && pready_reg;
  assign wr_en      = apb_access && pwrite;

  always_comb begin
    addr_hit = 1'b0;
    rd_next  = 32'h0000_0000;
    unique case (paddr)
      tsm_pkg::OFS_SERIAL_CTRL: begin
        addr_hit = 1'b1;
        rd_next[tsm_pkg::SER_SEL_LSB +: tsm_pkg::SER_SEL_W] = serial_observe_select;
        rd_next[tsm_pkg::ROUTE_BIT] = digital_test_route_bit;
      end
      tsm_pkg::OFS_DIG_SELECT: begin
        addr_hit = 1'b1;
        rd_next[tsm_pkg::DIG_SEL_W-1:0] = digital_test_select_reg;
      end
      tsm_pkg::OFS_ANA_SELECT: begin
        addr_hit = 1'b1;
        rd_next[tsm_pkg::ANA_SEL_W-1:0] = analog_test_select_reg;
      end
      tsm_pkg::OFS_STATUS: begin
        addr_hit = 1'b1;
        rd_next[tsm_pkg::STS_PIN_BIT]     = pin_reg;
        rd_next[tsm_pkg::STS_RSV_BIT]     = rsv_reg;
        rd_next[tsm_pkg::STS_ANA_RSV_BIT] = ana_rsv_reg;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // APB answer, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup && !addr_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata_reg <= rd_next;
    end else if (apb_access) begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Selection registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_observe_select  <= tsm_pkg::tsm_sersel_e'(tsm_pkg::RST_SER_SEL);
      digital_test_route_bit <= tsm_pkg::RST_ROUTE;
    end else if (wr_en && paddr == tsm_pkg::OFS_SERIAL_CTRL) begin
      serial_observe_select  <= tsm_pkg::tsm_sersel_e'(
        pwdata[tsm_pkg::SER_SEL_LSB +: tsm_pkg::SER_SEL_W]);
      digital_test_route_bit <= pwdata[tsm_pkg::ROUTE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_test_select_reg <= tsm_pkg::RST_DIG_SEL;
    end else if (wr_en && paddr == tsm_pkg::OFS_DIG_SELECT) begin
      digital_test_select_reg <= pwdata[tsm_pkg::DIG_SEL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_test_select_reg <= tsm_pkg::RST_ANA_SEL;
    end else if (wr_en && paddr == tsm_pkg::OFS_ANA_SELECT) begin
      analog_test_select_reg <= pwdata[tsm_pkg::ANA_SEL_W-1:0];
    end
  end

  // ==========================================================================
  // Serial signal switch
  always_comb begin
    ser_bit = 1'b0;
    ser_rsv = 1'b0;
    unique case (serial_observe_select)
      tsm_pkg::TSM_SER_LOW:      ser_bit = 1'b0;              // [RQ1]
      tsm_pkg::TSM_SER_HIGH:     ser_bit = 1'b1;              // [RQ1]
      tsm_pkg::TSM_SER_ENVELOPE: ser_bit = src.tx_envelope;   // [RQ3]
      tsm_pkg::TSM_SER_NRZ:      ser_bit = src.tx_nrz;        // [RQ2]
      tsm_pkg::TSM_SER_MANCH_SC: ser_bit = src.rx_manch_sub;  // [RQ4]
      tsm_pkg::TSM_SER_MANCH:    ser_bit = src.rx_manch;      // [RQ5]
      tsm_pkg::TSM_SER_RSV6:     ser_rsv = 1'b1;              // [RQ23]
      tsm_pkg::TSM_SER_RSV7:     ser_rsv = 1'b1;              // [RQ23]
    endcase
  end

  // ==========================================================================
  // Digital test source
  assign digital_test_source_field = digital_test_select_reg[tsm_pkg::DIG_FIELD_W-1:0];  // [RQ7]

  tsm_dig_mux u_dig_mux (
    .code     (digital_test_source_field),
    .src      (src),
    .dig_bit  (dig_bit),
    .dig_none (dig_none),
    .dig_rsv  (dig_rsv)
  );

  // ==========================================================================
  // Pin selection
  always_comb begin
    if (digital_test_route_bit && !dig_none) begin
      pin_next = dig_rsv ? 1'b0 : dig_bit;  // [RQ6] [RQ23]
      rsv_next = dig_rsv;
    end else begin
      pin_next = ser_rsv ? 1'b0 : ser_bit;  // [RQ15] [RQ23]
      rsv_next = ser_rsv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
      rsv_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      rsv_reg <= rsv_next;
    end
  end

  // ==========================================================================
  // Analog switch enables
  tsm_ana_decode #(
    .COUNT (tsm_pkg::ANA_COUNT)
  ) u_ana_decode (
    .sel   (analog_test_select_reg),
    .sw_en (ana_sw_next),
    .rsv   (ana_rsv_next)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_sw_reg  <= '0;
      ana_rsv_reg <= 1'b0;
    end else begin
      ana_sw_reg  <= ana_sw_next;   // [RQ19] [RQ20] [RQ21] [RQ22]
      ana_rsv_reg <= ana_rsv_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign serial_observe_pin = pin_reg;
  assign analog_switch_en   = ana_sw_reg;
  assign analog_park        = ana_rsv_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ser_low: // [RQ1]
    assert property (!digital_test_route_bit && serial_observe_select == tsm_pkg::TSM_SER_LOW
                     |=> !serial_observe_pin)
    else $error("Serial select 0 did not drive low");

  a_ser_high: // [RQ1]
    assert property (!digital_test_route_bit && serial_observe_select == tsm_pkg::TSM_SER_HIGH
                     |=> serial_observe_pin)
    else $error("Serial select 1 did not drive high");

  a_ser_nrz: // [RQ2]
    assert property (!digital_test_route_bit && serial_observe_select == tsm_pkg::TSM_SER_NRZ
                     |=> serial_observe_pin == $past(src.tx_nrz))
    else $error("NRZ transmit data not on pin");

  a_ser_envelope: // [RQ3]
    assert property (!digital_test_route_bit
                     && serial_observe_select == tsm_pkg::TSM_SER_ENVELOPE
                     |=> serial_observe_pin == $past(src.tx_envelope))
    else $error("Transmit envelope not on pin");

  a_ser_manch_sub: // [RQ4]
    assert property (!digital_test_route_bit
                     && serial_observe_select == tsm_pkg::TSM_SER_MANCH_SC
                     |=> serial_observe_pin == $past(src.rx_manch_sub))
    else $error("Manchester with subcarrier not on pin");

  a_ser_manch: // [RQ5]
    assert property (!digital_test_route_bit && serial_observe_select == tsm_pkg::TSM_SER_MANCH
                     |=> serial_observe_pin == $past(src.rx_manch))
    else $error("Manchester signal not on pin");

  a_dig_rx_data: // [RQ6] [RQ8]
    assert property (digital_test_route_bit
                     && digital_test_source_field == tsm_pkg::DIG_RX_DATA[6:0]
                     |=> serial_observe_pin == $past(src.rx_data))
    else $error("Received data not routed");

  a_dig_valid: // [RQ9]
    assert property (digital_test_route_bit
                     && digital_test_source_field == tsm_pkg::DIG_RX_VALID[6:0]
                     |=> serial_observe_pin == $past(src.rx_valid))
    else $error("Valid qualifier not routed");

  a_dig_coll: // [RQ10]
    assert property (digital_test_route_bit
                     && digital_test_source_field == tsm_pkg::DIG_RX_COLL[6:0]
                     |=> serial_observe_pin == $past(src.rx_coll))
    else $error("Collision flag not routed");

  a_dig_ser_clk: // [RQ11]
    assert property (digital_test_route_bit
                     && digital_test_source_field == tsm_pkg::DIG_SER_CLK[6:0]
                     |=> serial_observe_pin == $past(src.serial_clk))
    else $error("Serial clock not routed");

  a_dig_strobes: // [RQ12] [RQ13]
    assert property (digital_test_route_bit
                     && (digital_test_source_field == tsm_pkg::DIG_RD_SYNC[6:0]
                         || digital_test_source_field == tsm_pkg::DIG_WR_SYNC[6:0])
                     |=> serial_observe_pin == ($past(digital_test_source_field)
                         == tsm_pkg::DIG_RD_SYNC[6:0] ? $past(src.rd_sync)
                                                      : $past(src.wr_sync)))
    else $error("Host strobe not routed");

  a_dig_int_clk: // [RQ14]
    assert property (digital_test_route_bit
                     && digital_test_source_field == tsm_pkg::DIG_INT_CLK[6:0]
                     |=> serial_observe_pin == $past(src.int_clk))
    else $error("Internal clock not routed");

  a_dig_none: // [RQ15]
    assert property (digital_test_route_bit && digital_test_source_field == 7'h00
                     && serial_observe_select == tsm_pkg::TSM_SER_HIGH
                     ##1 $stable(digital_test_select_reg)
                     |-> serial_observe_pin)
    else $error("Code 00h did not fall back to serial switch");

  a_rsv_low: // [RQ23]
    assert property (rsv_reg |-> !serial_observe_pin)
    else $error("Reserved selection drove the pin");

  a_ana_onehot: // [RQ18] [RQ22]
    assert property (presetn && analog_test_select_reg < 5'(tsm_pkg::ANA_COUNT)
                     |=> analog_switch_en == (13'h0001 << $past(analog_test_select_reg))
                         && !analog_park)
    else $error("Analog switch does not match selection");

  a_ana_park: // [RQ22]
    assert property (analog_test_select_reg >= 5'(tsm_pkg::ANA_COUNT)
                     |=> analog_switch_en == '0 && analog_park)
    else $error("Reserved analog selection left a switch closed");

  a_apb_ready:
    assert property (psel && !penable |=> pready ##1 !pready)
    else $error("Access phase answer not one cycle");

endmodule // tsm_observe_top

`default_nettype wire

// ---- hw/tsm_pkg.sv ----
// Purpose: Shared constants and types of the test signal observation block
// Assumes: APB register access with 32-bit data, single clock domain
// Notes:   Digital test codes are compared on their low seven bits only

`default_nettype none

package tsm_pkg;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W            = 8;
  localparam logic [7:0]  OFS_SERIAL_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_DIG_SELECT    = 8'h04;
  localparam logic [7:0]  OFS_ANA_SELECT    = 8'h08;
  localparam logic [7:0]  OFS_STATUS        = 8'h0c;

  // ==========================================================================
  // Field layout
  localparam int          SER_SEL_LSB       = 0;
  localparam int          SER_SEL_W         = 3;
  localparam int          ROUTE_BIT         = 3;
  localparam int          DIG_SEL_W         = 8;
  localparam int          DIG_FIELD_W       = 7;
  localparam int          ANA_SEL_W         = 5;
  localparam int          ANA_COUNT         = 13;
  localparam int          STS_PIN_BIT       = 0;
  localparam int          STS_RSV_BIT       = 1;
  localparam int          STS_ANA_RSV_BIT   = 2;

  // ==========================================================================
  // Reset values
  localparam logic [2:0]  RST_SER_SEL       = 3'h0;
  localparam logic        RST_ROUTE         = 1'b0;
  localparam logic [7:0]  RST_DIG_SEL       = 8'h00;
  localparam logic [4:0]  RST_ANA_SEL       = 5'h00;

  // ==========================================================================
  // Digital test codes
  localparam logic [7:0]  DIG_RX_DATA       = 8'hf4;
  localparam logic [7:0]  DIG_RX_VALID      = 8'he4;
  localparam logic [7:0]  DIG_RX_COLL       = 8'hd4;
  localparam logic [7:0]  DIG_SER_CLK       = 8'hc4;
  localparam logic [7:0]  DIG_RD_SYNC       = 8'hb5;
  localparam logic [7:0]  DIG_WR_SYNC       = 8'ha5;
  localparam logic [7:0]  DIG_INT_CLK       = 8'h96;
  localparam logic [7:0]  DIG_NONE          = 8'h00;

  // ==========================================================================
  // Serial switch selections
  typedef enum logic [2:0] {
    TSM_SER_LOW      = 3'h0,
    TSM_SER_HIGH     = 3'h1,
    TSM_SER_ENVELOPE = 3'h2,
    TSM_SER_NRZ      = 3'h3,
    TSM_SER_MANCH_SC = 3'h4,
    TSM_SER_MANCH    = 3'h5,
    TSM_SER_RSV6     = 3'h6,
    TSM_SER_RSV7     = 3'h7
  } tsm_sersel_e;

  // ==========================================================================
  // Observable internal digital sources
  typedef struct packed {
    logic tx_envelope;
    logic tx_nrz;
    logic rx_manch_sub;
    logic rx_manch;
    logic rx_data;
    logic rx_valid;
    logic rx_coll;
    logic serial_clk;
    logic rd_sync;
    logic wr_sync;
    logic int_clk;
  } tsm_src_s;

endpackage : tsm_pkg

`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench of the observation multiplexers
// Assumes: Zero-wait APB slave, one cycle from register to pin
// Notes:   A reference model follows every accepted write

`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, r;
  logic        pready, pslverr, serial_observe_pin, analog_park, er;
  logic [tsm_pkg::ANA_COUNT-1:0] analog_switch_en, exp_sw = '0;
  tsm_pkg::tsm_src_s src;
  integer seed = 32'h59ab;
  int     n_fail = 0, tests_run = 0, cycles = 0;
  logic [2:0] m_sel = '0;
  logic       m_route = 0, exp_pin = 0, exp_park = 0, armed = 0;
  logic [7:0] m_dig = '0;
  logic [4:0] m_ana = '0;
  logic [7:0] codes [10] = '{8'hf4, 8'he4, 8'hd4, 8'hc4, 8'hb5, 8'ha5, 8'h96, 8'h00, 8'h12, 8'h74};

  always #2.5 pclk = ~pclk;

  tsm_observe_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src(src), .serial_observe_pin(serial_observe_pin),
    .analog_switch_en(analog_switch_en), .analog_park(analog_park));
  tsm_src_model u_src (.pclk(pclk), .presetn(presetn), .src(src));

  // ==========================================================================
  // Reference model
  function automatic logic f_pin(logic [2:0] s, logic rt, logic [7:0] d, tsm_pkg::tsm_src_s x);
    if (!rt || d[6:0] == 7'h00) begin
      case (s)
        3'h1: return 1'b1;
        3'h2: return x.tx_envelope;
        3'h3: return x.tx_nrz;
        3'h4: return x.rx_manch_sub;
        3'h5: return x.rx_manch;
        default: return 1'b0;
      endcase
    end
    case (d[6:0])
      7'h74: return x.rx_data;
      7'h64: return x.rx_valid;
      7'h54: return x.rx_coll;
      7'h44: return x.serial_clk;
      7'h35: return x.rd_sync;
      7'h25: return x.wr_sync;
      7'h16: return x.int_clk;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic f_rsv(logic [2:0] s, logic rt, logic [7:0] d);
    if (!rt || d[6:0] == 7'h00) begin
      return s >= 3'h6;
    end
    return !(d[6:0] inside {7'h74, 7'h64, 7'h54, 7'h44, 7'h35, 7'h25, 7'h16});
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // APB master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
    if (w && er !== 1'b1) begin
      case (a)
        8'h00: begin
          m_sel <= d[2:0];
          m_route <= d[3];
        end
        8'h04: m_dig <= d[7:0];
        8'h08: m_ana <= d[4:0];
        default: ;
      endcase
    end
  endtask

  task automatic idle(int k);
    psel <= 1'b0;
    repeat (k) @(posedge pclk);
  endtask

  task automatic read_status;
    apb(1'b0, 8'h0c, 32'h0);
    check("status", rd & 32'h6, {29'h0, m_ana >= 5'd13, f_rsv(m_sel, m_route, m_dig), 1'b0});
  endtask

  // ==========================================================================
  // Pin and switch monitor, timeout
  always @(posedge pclk) begin
    armed <= presetn;
    exp_pin <= f_pin(m_sel, m_route, m_dig, src);
    exp_sw <= (m_ana < 5'd13) ? 13'h1 << m_ana : 13'h0;
    exp_park <= m_ana >= 5'd13;
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      final_report;
    end
  end
  always @(negedge pclk) begin
    if (armed) begin
      check("pin", {31'h0, serial_observe_pin}, {31'h0, exp_pin});
      check("switch", {19'h0, analog_switch_en}, {19'h0, exp_sw});
      check("park", {31'h0, analog_park}, {31'h0, exp_park});
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl_rst", rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check("dig_rst", rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    check("ana_rst", rd, 32'h0);
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    check("sts_err", {31'h0, er}, 32'h0);
    apb(1'b1, 8'h10, 32'h7);
    check("bad_werr", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check("bad_rd", rd, 32'h0);
    check("bad_rerr", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl_kept", rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h00, 32'(i));
      idle(20);
      read_status();
    end
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      apb(1'b1, 8'h00, {28'h0, 1'b1, r[2:0]});
      apb(1'b1, 8'h04, {r[31:8], codes[i]});
      apb(1'b0, 8'h04, 32'h0);
      check("dig_rd", rd, {24'h0, codes[i]});
      idle(20);
      read_status();
    end
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      apb(1'b1, 8'h08, {r[31:5], 5'(i)});
      apb(1'b0, 8'h08, 32'h0);
      check("ana_rd", rd, 32'(i));
      idle(3);
    end
    repeat (40) begin
      r = $random(seed);
      if (r[1:0] == 2'b01) begin
        apb(1'b1, 8'h04, {24'h0, codes[r[7:4] % 8]});
      end else begin
        apb(1'b1, (r[1:0] == 2'b10) ? 8'h08 : 8'h00, r);
      end
      idle(int'(r[10:8]) + 1);
    end
    apb(1'b1, 8'h00, 32'h9);
    apb(1'b1, 8'h04, 32'h0);
    idle(5);
    read_status();
    idle(2);
    final_report;
  end
endmodule // tb_top

`default_nettype wire

// ---- test/tsm_src_model.sv ----
// Purpose: Model of the internal sources that the observer watches
// Assumes: Sources are levels that change just after a pclk rising edge
// Notes:   Holds values for random stretches to mimic slow sources

`default_nettype none

module tsm_src_model (
  input  wire logic         pclk,
  input  wire logic         presetn,
  output var tsm_pkg::tsm_src_s src
);
  timeunit 1ns;
  timeprecision 1ps;
  integer      seed = 32'h59ab;
  logic [31:0] r;

  // ==========================================================================
  // Random levels, internal clock toggles whenever the levels are updated (r[31:30] not 00)
  always @(posedge pclk) begin
    r = $random(seed);
    if (!presetn) begin
      src <= '0;
    end else if (r[31:30] != 2'b00) begin
      src <= tsm_pkg::tsm_src_s'({r[10:1], ~src.int_clk});
    end
  end
endmodule // tsm_src_model

`default_nettype wire
